// *** bbt_pkg.sv ***
// Purpose: shared constants and types for the branch and bit-test executor
// Assumes: 8-bit data, 16-bit address, one read per clock
// Notes: condition code byte laid out as S X H I N Z V C
package bbt_pkg;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_BRANCH_CARRY_CLEAR = 8'h24;
    localparam logic [7:0] OP_BRANCH_SIGNED_LESS = 8'h2d;
    localparam logic [7:0] OP_BRANCH_SIGNED_GREATER_EQUAL = 8'h2c;
    localparam logic [7:0] OP_PREFIX_Y = 8'h18;
    localparam logic [7:0] OP_TBA_IMM = 8'h85;
    localparam logic [7:0] OP_TBA_DIR = 8'h95;
    localparam logic [7:0] OP_TBA_EXT = 8'hb5;
    localparam logic [7:0] OP_TBA_IDX = 8'ha5;
    localparam logic [7:0] OP_TBA_IDY = 8'hab;
    localparam logic [7:0] OP_TBB_IMM = 8'hc5;
    localparam logic [7:0] OP_TBB_DIR = 8'hd5;
    localparam logic [7:0] OP_TBB_EXT = 8'hf5;
    localparam logic [7:0] OP_TBB_IDX = 8'he5;
    localparam logic [7:0] OP_TBB_IDY = 8'heb;

    // ----------------------------------------------------------------
    // addresses, field positions, reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DUMMY_ADDR = 16'hffff;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [7:0] CCR_RESET = 8'h00;
    localparam int CCR_N = 3;
    localparam int CCR_Z = 2;
    localparam int CCR_V = 1;
    localparam int CCR_C = 0;
    localparam logic BUS_READ = 1'b1;

    // one bus cycle as the core presents it
    typedef struct packed {
        logic [15:0] addr;
        logic rw;
    } bbt_bus_req_t;

    typedef enum logic [3:0] {
        ST_FETCH = 4'h0,
        ST_PREFIX = 4'h1,
        ST_OFFSET = 4'h2,
        ST_BR_DUMMY = 4'h3,
        ST_IMM = 4'h4,
        ST_DIR = 4'h5,
        ST_EXT_HI = 4'h6,
        ST_EXT_LO = 4'h7,
        ST_IDX_OFF = 4'h8,
        ST_IDX_DUMMY = 4'h9,
        ST_OPERAND = 4'ha
    } bbt_state_t;
endpackage : bbt_pkg

// *** bbt_exec.sv ***
// Purpose: executes relative branches and the bit-test instruction
// Assumes: memory returns read data in the same cycle as the address
// Notes: accumulators and index registers belong to the wider core
`timescale 1ns/10ps
`default_nettype none
module bbt_exec
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // memory bus
    output var bbt_pkg::bbt_bus_req_t busReq,
    input wire logic [7:0] busRdData,
    // core register file
    input wire logic [7:0] accA,
    input wire logic [7:0] accB,
    input wire logic [15:0] indexX,
    input wire logic [15:0] indexY,
    // architectural state and status pulses
    output logic [15:0] progCounter,
    output logic [7:0] condCodes,
    output logic instrDone,
    output logic unknownOp
);
    import bbt_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rstMeta_q;
    logic rstSync_q;
    logic rstn;

    // assertion stays asynchronous, release is timed to clk
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rstn = rstSync_q;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bbt_state_t state_q;
    bbt_state_t state_d;
    logic [15:0] pc_q;
    logic [7:0] ccr_q;
    logic [15:0] opAddr_q;
    logic useAccB_q;
    logic useY_q;
    logic [7:0] branchOp_q;
    logic [7:0] testResult;
    logic branchTaken;
    logic testUpdate;

    // selected accumulator and memory operand, nothing stored back
    assign testResult = (useAccB_q ? accB : accA) & busRdData;

    // the condition is read from the flags left by the previous instruction
    always_comb
    begin
        unique case (branchOp_q)
            OP_BRANCH_CARRY_CLEAR: branchTaken = ~ccr_q[CCR_C];
            OP_BRANCH_SIGNED_LESS: branchTaken = ccr_q[CCR_N] ^ ccr_q[CCR_V];
            default: branchTaken = ~(ccr_q[CCR_N] ^ ccr_q[CCR_V]);
        endcase
    end

    assign testUpdate = (state_q == ST_IMM) || (state_q == ST_OPERAND);

    // ----------------------------------------------------------------
    // bus address per state; every cycle is a read
    // ----------------------------------------------------------------
    always_comb
    begin
        busReq.rw = BUS_READ;
        unique case (state_q)
            ST_BR_DUMMY: busReq.addr = DUMMY_ADDR;
            ST_IDX_DUMMY: busReq.addr = DUMMY_ADDR;
            ST_OPERAND: busReq.addr = opAddr_q;
            default: busReq.addr = pc_q;
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = ST_FETCH;
        unique case (state_q)
            ST_FETCH:
            begin
                unique case (busRdData)
                    OP_PREFIX_Y: state_d = ST_PREFIX;
                    OP_BRANCH_CARRY_CLEAR,
                    OP_BRANCH_SIGNED_LESS,
                    OP_BRANCH_SIGNED_GREATER_EQUAL: state_d = ST_OFFSET;
                    OP_TBA_IMM, OP_TBB_IMM: state_d = ST_IMM;
                    OP_TBA_DIR, OP_TBB_DIR: state_d = ST_DIR;
                    OP_TBA_EXT, OP_TBB_EXT: state_d = ST_EXT_HI;
                    OP_TBA_IDX, OP_TBB_IDX: state_d = ST_IDX_OFF;
                    default: state_d = ST_FETCH;
                endcase
            end
            ST_PREFIX:
            begin
                if (busRdData == OP_TBA_IDY || busRdData == OP_TBB_IDY)
                begin
                    state_d = ST_IDX_OFF;
                end
            end
            ST_OFFSET: state_d = ST_BR_DUMMY;
            ST_DIR: state_d = ST_OPERAND;
            ST_EXT_HI: state_d = ST_EXT_LO;
            ST_EXT_LO: state_d = ST_OPERAND;
            ST_IDX_OFF: state_d = ST_IDX_DUMMY;
            ST_IDX_DUMMY: state_d = ST_OPERAND;
            default: state_d = ST_FETCH;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_FETCH;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // instruction context
    // ----------------------------------------------------------------
    // decode latches what later cycles need
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            useAccB_q <= 1'b0;
            useY_q <= 1'b0;
            branchOp_q <= OP_BRANCH_CARRY_CLEAR;
        end
        else if (state_q == ST_FETCH)
        begin
            useAccB_q <= (busRdData[7:4] >= 4'hc); // B opcodes live in C..F
            useY_q <= 1'b0;
            branchOp_q <= busRdData;
        end
        else if (state_q == ST_PREFIX)
        begin
            useAccB_q <= (busRdData == OP_TBB_IDY);
            useY_q <= 1'b1;
        end
    end

    // effective operand address built from the fetched bytes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opAddr_q <= PC_RESET;
        end
        else
        begin
            unique case (state_q)
                ST_DIR: opAddr_q <= {8'h00, busRdData};
                ST_EXT_HI: opAddr_q <= {busRdData, 8'h00};
                ST_EXT_LO: opAddr_q <= {opAddr_q[15:8], busRdData};
                // offset is unsigned for indexed modes
                ST_IDX_OFF: opAddr_q <= (useY_q ? indexY : indexX) + {8'h00, busRdData};
                default: opAddr_q <= opAddr_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    // pc still points at the offset byte when the branch resolves, so one step is added
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc_q <= PC_RESET;
        end
        else
        begin
            unique case (state_q)
                ST_BR_DUMMY, ST_IDX_DUMMY, ST_OPERAND: pc_q <= pc_q;
                ST_OFFSET:
                begin
                    if (branchTaken)
                    begin
                        pc_q <= pc_q + PC_STEP + {{8{busRdData[7]}}, busRdData};
                    end
                    else
                    begin
                        pc_q <= pc_q + PC_STEP;
                    end
                end
                default: pc_q <= pc_q + PC_STEP;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // condition codes
    // ----------------------------------------------------------------
    // only N, Z and V move; carry and the rest are left alone
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ccr_q <= CCR_RESET;
        end
        else if (testUpdate)
        begin
            ccr_q[CCR_N] <= testResult[7];
            ccr_q[CCR_Z] <= (testResult == 8'h00);
            ccr_q[CCR_V] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    // pulses mark the fetch cycle after an instruction ends or an opcode is dropped
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            instrDone <= 1'b0;
            unknownOp <= 1'b0;
        end
        else
        begin
            instrDone <= testUpdate || (state_q == ST_BR_DUMMY);
            // a refused byte is a fetch or prefix cycle that falls back to fetch
            unknownOp <= (state_d == ST_FETCH) &&
                ((state_q == ST_FETCH) || (state_q == ST_PREFIX));
        end
    end

    assign progCounter = pc_q;
    assign condCodes = ccr_q;
endmodule : bbt_exec
`default_nettype wire

// *** bbt_exec_monitor.sv ***
// Purpose: bus and flag checks beside the executor
// Assumes: a done or refusal pulse marks each fetch cycle
// Notes: the first fetch after reset goes unwatched
`timescale 1ns/10ps
`default_nettype none
module bbt_exec_monitor
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus and state
    input wire bbt_pkg::bbt_bus_req_t busReq,
    input wire logic [7:0] busRdData,
    input wire logic [7:0] accA,
    input wire logic [7:0] accB,
    input wire logic [15:0] indexX,
    input wire logic [7:0] condCodes,
    input wire logic instrDone,
    input wire logic unknownOp
);
    import bbt_pkg::*;
    logic [7:0] d;
    logic f, br, go, pfx, sel, bitOp;
    logic [7:0] res;
    logic [15:0] t1, t2;
    // fetch marker, branch decode (2c and 2d differ in bit 0)
    assign d = busRdData;
    assign f = instrDone | unknownOp;
    assign br = d == OP_BRANCH_CARRY_CLEAR || d[7:1] == 7'h16;
    assign go = d == OP_BRANCH_CARRY_CLEAR ? !condCodes[CCR_C]
        : d[0] == (condCodes[CCR_N] ^ condCodes[CCR_V]);
    // target and result delayed until the cycle they show up in
    always_ff @(posedge clk)
    begin
        t1 <= busReq.addr + 16'h1 + {{8{d[7]}}, d};
        t2 <= t1;
        res <= d & (sel ? accB : accA);
        pfx <= f && d == OP_PREFIX_Y;
        if (f || pfx)
            sel <= d[6];
        if (f)
            bitOp <= (d[7] && d[3:0] == 4'h5) || d == OP_PREFIX_Y;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    read_only_a: assert property (busReq.rw == BUS_READ)
        else $error("write cycle seen");
    branch_seq_a: assert property (f && d == OP_BRANCH_CARRY_CLEAR |=>
        busReq.addr == $past(busReq.addr) + 16'h1 ##1 busReq.addr == DUMMY_ADDR ##1 instrDone)
        else $error("branch bus cycles wrong");
    branch_taken_a: assert property (f && br && go |-> ##3 busReq.addr == t2)
        else $error("taken branch target wrong");
    branch_skip_a: assert property (f && br && !go |->
        ##3 busReq.addr == $past(busReq.addr, 3) + 16'h2) else $error("untaken branch wrong");
    bit_flags_a: assert property (instrDone && bitOp |->
        condCodes[CCR_N] == res[7] && condCodes[CCR_Z] == (res == 8'h00) && !condCodes[CCR_V])
        else $error("bit test flags wrong");
    direct_addr_a: assert property (f && d[7] && d[5:0] == 6'h15 |->
        ##2 busReq.addr == {8'h00, $past(d)} ##1 instrDone) else $error("direct cycles wrong");
    extended_addr_a: assert property (f && d[7] && d[5:0] == 6'h35 |->
        ##3 busReq.addr == {$past(d, 2), $past(d)} ##1 instrDone)
        else $error("extended cycles wrong");
    indexed_addr_a: assert property (f && d[7] && d[5:0] == 6'h25 |->
        ##2 busReq.addr == DUMMY_ADDR ##1 busReq.addr == indexX + {8'h00, $past(d, 2)}
        ##1 instrDone) else $error("indexed cycles wrong");
endmodule : bbt_exec_monitor
bind bbt_exec bbt_exec_monitor chk (.clk(clk), .resetn(resetn), .busReq(busReq),
    .busRdData(busRdData), .accA(accA), .accB(accB), .indexX(indexX),
    .condCodes(condCodes), .instrDone(instrDone), .unknownOp(unknownOp));
`default_nettype wire

// *** bbt_mem_model.sv ***
// Purpose: zero-wait program and data memory
// Assumes: reads only, data given in the address cycle
// Notes: the bench fills bytes through the array
`timescale 1ns/10ps
`default_nettype none
module bbt_mem_model
(
    // clock
    input wire logic clk,
    // bus
    input wire bbt_pkg::bbt_bus_req_t busReq,
    output logic [7:0] busRdData
);
    import bbt_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] junk = 8'h5a;
    // nothing answers at the dummy address, so its data moves every cycle
    always @(posedge clk)
        junk <= {junk[6:0], ~junk[7]};
    assign busRdData = (busReq.addr == DUMMY_ADDR) ? junk : mem[busReq.addr];
endmodule : bbt_mem_model
`default_nettype wire

// *** tb_branch_and_bit_test_exec.sv ***
// Purpose: self-checking bench for the executor
// Assumes: memory answers in the address cycle
// Notes: nothing here sets carry, so 24 is always taken
`timescale 1ns/10ps
`default_nettype none
module tb_branch_and_bit_test_exec;
    import bbt_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, instrDone, unknownOp;
    logic [7:0] accA = 8'h00, accB = 8'h00, condCodes, busRdData, ccrExp = 8'h00;
    logic [15:0] indexX = 16'h0500, indexY = 16'h0600, progCounter, pc = 16'h0000;
    bbt_bus_req_t busReq;
    int miscompares = 0, checkCount = 0;
    logic [7:0] ops [10] = '{OP_TBA_IMM, OP_TBA_DIR, OP_TBA_EXT, OP_TBA_IDX, OP_TBA_IDY,
        OP_TBB_IMM, OP_TBB_DIR, OP_TBB_EXT, OP_TBB_IDX, OP_TBB_IDY};
    bbt_exec uut (.clk(clk), .resetn(resetn), .busReq(busReq), .busRdData(busRdData),
        .accA(accA), .accB(accB), .indexX(indexX), .indexY(indexY), .progCounter(progCounter),
        .condCodes(condCodes), .instrDone(instrDone), .unknownOp(unknownOp));
    bbt_mem_model memModel (.clk(clk), .busReq(busReq), .busRdData(busRdData));
    initial
        forever #2 clk = ~clk;
    // ----------------------------------------------------------------
    // shared steps: bytes are placed during the fetch cycle that reads them
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic put(input logic [15:0] a, input logic [7:0] v);
        memModel.mem[a] = v;
    endtask : put
    task automatic await(input int cyc, input logic [15:0] nxt, input logic bad);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (instrDone !== 1'b1 && unknownOp !== 1'b1 && n < 9);
        check("cycles", 16'(n), 16'(cyc));
        check("refused", {15'h0, unknownOp}, {15'h0, bad});
        check("next fetch", busReq.addr, nxt);
        check("program counter", progCounter, nxt);
        check("flags", {8'h00, condCodes}, {8'h00, ccrExp});
        check("read only", {15'h0, busReq.rw}, 16'h1);
        pc = nxt;
    endtask : await
    task automatic bit_op(input int m, input logic b, input logic [7:0] acc, input logic [7:0] v);
        logic [15:0] p;
        p = pc;
        accA = b ? ~acc : acc;
        accB = b ? acc : ~acc;
        if (m == 4)
        begin
            put(p, OP_PREFIX_Y);
            p = p + 16'h1;
        end
        put(p, ops[5 * b + m]);
        put(p + 16'h1, m == 0 ? v : m == 1 ? 8'h80 : m == 2 ? 8'h03 : 8'hf0);
        put(p + 16'h2, 8'h40);
        if (m != 0)
            put(m == 1 ? 16'h0080 : m == 2 ? 16'h0340 : (m == 3 ? indexX : indexY) + 16'hf0, v);
        ccrExp[CCR_N] = acc[7] & v[7];
        ccrExp[CCR_Z] = (acc & v) == 8'h00;
        ccrExp[CCR_V] = 1'b0;
        await(m < 2 ? m + 2 : m == 4 ? 5 : 4, p + (m == 2 ? 16'h3 : 16'h2), 1'b0);
    endtask : bit_op
    task automatic branch(input logic [7:0] op, input logic [7:0] off);
        logic go;
        go = op == OP_BRANCH_CARRY_CLEAR ? !ccrExp[CCR_C]
            : (op == OP_BRANCH_SIGNED_LESS) == (ccrExp[CCR_N] ^ ccrExp[CCR_V]);
        put(pc, op);
        put(pc + 16'h1, off);
        await(3, pc + 16'h2 + (go ? {{8{off[7]}}, off} : 16'h0), 1'b0);
    endtask : branch
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        repeat (4) @(posedge clk);
        #1;
        check("reset addr", busReq.addr, PC_RESET);
        check("reset flags", {8'h00, condCodes}, {8'h00, CCR_RESET});
        resetn = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        bit_op(0, 1'b0, 8'h0f, 8'hf0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_bits();
        for (int b = 0; b < 2; b++)
            for (int m = 0; m < 5; m++)
                bit_op(m, b[0], b ? 8'h81 : 8'hc3, m == 4 ? 8'h7f : m[0] ? 8'h80 : 8'h3c);
        $display("test bit modes done");
    endtask : t_bits
    task automatic t_branch();
        bit_op(0, 1'b0, 8'h80, 8'h80);
        branch(OP_BRANCH_SIGNED_LESS, 8'h7f);
        branch(OP_BRANCH_SIGNED_GREATER_EQUAL, 8'h10);
        bit_op(0, 1'b1, 8'h01, 8'h01);
        branch(OP_BRANCH_SIGNED_LESS, 8'h05);
        branch(OP_BRANCH_SIGNED_GREATER_EQUAL, 8'h80);
        branch(OP_BRANCH_CARRY_CLEAR, 8'h7f);
        branch(OP_BRANCH_CARRY_CLEAR, 8'hfe);
        $display("test branches done");
    endtask : t_branch
    task automatic t_refuse();
        put(pc, 8'h01);
        await(1, pc + 16'h1, 1'b1);
        put(pc, OP_PREFIX_Y);
        put(pc + 16'h1, 8'h00);
        await(2, pc + 16'h2, 1'b1);
        $display("test refusals done");
    endtask : t_refuse
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // the whole run needs about 70 cycles; the 1500-cycle limit means a hang
    initial
    begin
        #6000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        t_reset();
        t_bits();
        t_branch();
        t_refuse();
        stop_test();
    end
endmodule : tb_branch_and_bit_test_exec
`default_nettype wire
